// *** i2c_target_pkg.sv ***
// constants, state and carrier types for the two-wire register target port
// assumes a 25 MHz system clock and a bus master that owns scl and sda timing
package i2c_target_pkg;

  // seven-bit target address and the direction bit that selects a read
  localparam logic [6:0] OWN_ADDR = 7'h59;
  localparam logic RW_READ = 1'b1;

  // a byte is eight data bits; the ninth slot is the acknowledge
  localparam int BYTE_BITS = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;

  // output data hold after scl falls, 300 ns least, rounded up to cycles
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_HOLD_NS = 300;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 4;
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC);
  localparam logic [HOLD_W-1:0] HOLD_FIRE = 4'h1;
  localparam logic [HOLD_W-1:0] HOLD_IDLE = 4'h0;

  // write queue towards the register file
  localparam int FIFO_DEPTH = 16;

  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_INDEX,
    ST_DATA,
    ST_READ,
    ST_IGNORE
  } port_state_e;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] data;
  } wr_req_s;

  localparam int WR_REQ_W = $bits(wr_req_s);

endpackage : i2c_target_pkg

// *** i2c_register_target_port.sv ***
// two-wire target port that turns bus writes into queued register writes
// and answers bus reads from a register file held outside this block
// assumes scl and sda arrive asynchronously from pins with pull-ups, and the
// register file answers rd_data_i combinationally from rd_index_o
`timescale 1ns/1ns

module reg_write_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,               // system clock
  input wire logic rstn_i,              // async reset, active low
  input wire logic in_valid_i,          // word offered
  output logic in_ready_o,              // room for a word
  input wire logic [WIDTH-1:0] in_data_i, // word to store
  output logic out_valid_o,             // word available
  input wire logic out_ready_i,         // consumer takes the word
  output logic [WIDTH-1:0] out_data_o   // oldest word
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] COUNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] COUNT_ZERO = '0;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic [AW:0] count_nxt;
  logic full_r;
  logic empty_r;
  logic push;
  logic pop;
  logic [AW-1:0] rd_ptr_nxt;
  logic [WIDTH-1:0] head_r;
  logic valid_r;

  assign push = in_valid_i & ~full_r;
  assign pop = ~empty_r & out_ready_i;
  assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
  assign rd_ptr_nxt = pop ? rd_ptr_r + AW'(1) : rd_ptr_r;
  assign in_ready_o = ~full_r;
  assign out_valid_o = valid_r;
  assign out_data_o = head_r;

  // the head word sits in its own flop so the consumer never sees a read
  // mux; a word landing in the slot that becomes the head is forwarded
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
    if (push && (wr_ptr_r == rd_ptr_nxt)) begin
      head_r <= in_data_i;
    end else begin
      head_r <= mem_r[rd_ptr_nxt];
    end
  end

  // flags are registered with the count so both sides see stable levels
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      full_r <= 1'b0;
      empty_r <= 1'b1;
      valid_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      count_r <= count_nxt;
      full_r <= (count_nxt == COUNT_FULL);
      empty_r <= (count_nxt == COUNT_ZERO);
      valid_r <= (count_nxt != COUNT_ZERO);
    end
  end

endmodule : reg_write_fifo

module i2c_register_target_port (
  input wire logic sys_clk_i,                  // 25 mhz system clock
  input wire logic rstn_i,                     // async reset, active low
  input wire logic scl_i,                      // bus clock pin level
  input wire logic sda_i,                      // bus data pin level
  output logic sda_o,                          // sda drive value, always low
  output logic sda_oe_o,                       // high while pulling sda low
  output logic scl_o,                          // scl drive value, always low
  output logic scl_oe_o,                       // high while stretching scl
  output logic busy_o,                         // bus occupied
  output logic wr_valid_o,                     // queued write available
  input wire logic wr_ready_i,                 // register file takes write
  output i2c_target_pkg::wr_req_s wr_req_o,    // index and value to write
  output logic [7:0] rd_index_o,               // selected register index
  input wire logic [7:0] rd_data_i             // value of selected register
);
  import i2c_target_pkg::*;

  logic scl_meta_r;
  logic scl_sync_r;
  logic scl_prev_r;
  logic sda_meta_r;
  logic sda_sync_r;
  logic sda_prev_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [HOLD_W-1:0] hold_cnt_r;
  logic act_fall;
  port_state_e state_r;
  logic [CNT_W-1:0] bit_cnt_r;
  logic in_ack_r;
  logic [7:0] shift_r;
  logic [7:0] index_r;
  logic sda_oe_r;
  logic scl_oe_r;
  logic busy_r;
  logic push_r;
  wr_req_s req_r;
  logic fifo_in_ready;
  logic [WR_REQ_W-1:0] fifo_out;
  logic active;

  // both lines pass two flops before anything looks at them
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_i;
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_meta_r <= sda_i;
      sda_sync_r <= sda_meta_r;
      sda_prev_r <= sda_sync_r;
    end
  end

  assign scl_rise = scl_sync_r & ~scl_prev_r;
  assign scl_fall = ~scl_sync_r & scl_prev_r;
  // sda moving while scl stays high is a bus condition, never data
  assign start_det = scl_sync_r & scl_prev_r & sda_prev_r & ~sda_sync_r;
  assign stop_det = scl_sync_r & scl_prev_r & ~sda_prev_r & sda_sync_r;

  // sda changes wait a hold time after scl falls, so the master never sees
  // our data move near its own clock edge
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hold_cnt_r <= HOLD_IDLE;
    end else if (scl_fall) begin
      hold_cnt_r <= HOLD_LOAD;
    end else if (hold_cnt_r != HOLD_IDLE) begin
      hold_cnt_r <= hold_cnt_r - HOLD_FIRE;
    end
  end

  assign act_fall = (hold_cnt_r == HOLD_FIRE);
  assign active = (state_r != ST_IDLE) && (state_r != ST_IGNORE);

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_r <= 1'b0;
    end else if (start_det) begin
      busy_r <= 1'b1;
    end else if (stop_det) begin
      busy_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= CNT_ZERO;
      in_ack_r <= 1'b0;
      shift_r <= BYTE_ZERO;
      index_r <= BYTE_ZERO;
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
      push_r <= 1'b0;
      req_r <= '0;
    end else begin
      push_r <= 1'b0;
      if (start_det) begin
        // a repeated start is handled just like the first one
        state_r <= ST_ADDR;
        bit_cnt_r <= CNT_ZERO;
        in_ack_r <= 1'b0;
        sda_oe_r <= 1'b0;
        scl_oe_r <= 1'b0;
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        bit_cnt_r <= CNT_ZERO;
        in_ack_r <= 1'b0;
        sda_oe_r <= 1'b0;
        scl_oe_r <= 1'b0;
      end else begin
        // stretch ends as soon as the write queue has room
        if (scl_oe_r && fifo_in_ready) begin
          scl_oe_r <= 1'b0;
        end
        if (scl_rise && active) begin
          if (!in_ack_r) begin
            shift_r <= {shift_r[6:0], sda_sync_r};
            bit_cnt_r <= bit_cnt_r + CNT_FULL[CNT_W-1:0] / CNT_FULL;
          end else begin
            unique case (state_r)
              ST_DATA: begin
                // the write leaves for the register file on this ack edge
                req_r <= '{index: index_r, data: shift_r};
                push_r <= 1'b1;
                index_r <= index_r + 8'h01;
              end
              ST_READ: begin
                if (sda_sync_r) begin
                  state_r <= ST_IGNORE;
                end else begin
                  index_r <= index_r + 8'h01;
                end
              end
              ST_ADDR, ST_INDEX, ST_IDLE, ST_IGNORE: begin
              end
            endcase
          end
        end
        if (act_fall && active) begin
          if (!in_ack_r && bit_cnt_r == CNT_FULL) begin
            in_ack_r <= 1'b1;
            unique case (state_r)
              ST_ADDR: begin
                if (shift_r[7:1] == OWN_ADDR) begin
                  sda_oe_r <= 1'b1;
                end else begin
                  state_r <= ST_IGNORE;
                  sda_oe_r <= 1'b0;
                end
              end
              ST_INDEX: begin
                index_r <= shift_r;
                sda_oe_r <= 1'b1;
              end
              ST_DATA: begin
                sda_oe_r <= 1'b1;
                if (!fifo_in_ready) begin
                  scl_oe_r <= 1'b1;
                end
              end
              ST_READ: begin
                sda_oe_r <= 1'b0;
              end
              ST_IDLE, ST_IGNORE: begin
              end
            endcase
          end else if (in_ack_r) begin
            in_ack_r <= 1'b0;
            bit_cnt_r <= CNT_ZERO;
            unique case (state_r)
              ST_ADDR: begin
                if (shift_r[0] == RW_READ) begin
                  // index was chosen by an earlier write phase
                  state_r <= ST_READ;
                  shift_r <= rd_data_i;
                  sda_oe_r <= ~rd_data_i[7];
                end else begin
                  state_r <= ST_INDEX;
                  sda_oe_r <= 1'b0;
                end
              end
              ST_INDEX: begin
                state_r <= ST_DATA;
                sda_oe_r <= 1'b0;
              end
              ST_DATA: begin
                sda_oe_r <= 1'b0;
              end
              ST_READ: begin
                shift_r <= rd_data_i;
                sda_oe_r <= ~rd_data_i[7];
              end
              ST_IDLE, ST_IGNORE: begin
              end
            endcase
          end else if (state_r == ST_READ) begin
            // open-drain: a one is sent by letting the line float
            sda_oe_r <= ~shift_r[7];
          end
        end
      end
    end
  end

  reg_write_fifo #(
    .WIDTH(WR_REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(push_r),
    .in_ready_o(fifo_in_ready),
    .in_data_i(req_r),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(fifo_out)
  );

  assign wr_req_o = wr_req_s'(fifo_out);
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe_o = sda_oe_r;
  assign scl_oe_o = scl_oe_r;
  assign busy_o = busy_r;
  assign rd_index_o = index_r;

endmodule : i2c_register_target_port

// *** i2c_target_checker.sv ***
// assertions on the pins of the two-wire register target port
// assumes scl_i and sda_i carry the wired bus levels seen by the port
`timescale 1ns/1ns

module i2c_target_checker (
  input wire logic sys_clk_i, // system clock
  input wire logic rstn_i, // async reset, active low
  input wire logic scl_i, // scl line
  input wire logic sda_i, // sda line
  input wire logic sda_o, // sda drive value
  input wire logic sda_oe_o, // sda pull enable
  input wire logic scl_o, // scl drive value
  input wire logic scl_oe_o, // scl stretch enable
  input wire logic busy_o, // bus occupied
  input wire logic wr_valid_o, // queued write available
  input wire logic wr_ready_i, // consumer ready
  input wire i2c_target_pkg::wr_req_s wr_req_o, // queue head
  input wire logic [7:0] rd_index_o // selected index
);
  import i2c_target_pkg::*;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // pin fall plus sync plus hold: the drive moves at least 9 edges later
  oe_after_fall_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 9))
    else $error("sda drive moved outside the late low phase");
  ack_hold_a: assert property ($rose(sda_oe_o) |=> sda_oe_o [*8])
    else $error("sda pull dropped early");
  start_busy_a: assert property (scl_i && $fell(sda_i) |-> ##[1:6] busy_o)
    else $error("start not seen");
  stop_idle_a: assert property (scl_i && $rose(sda_i) |-> ##[1:6] !busy_o)
    else $error("stop not seen");
  idle_release_a: assert property ((!busy_o) [*3] |-> !sda_oe_o)
    else $error("sda pulled while bus idle");
  open_drain_a: assert property (sda_oe_o || scl_oe_o |-> !sda_o && !scl_o)
    else $error("drive value not low");
  stretch_full_a: assert property ($rose(scl_oe_o) |-> wr_valid_o && !wr_ready_i)
    else $error("stretch without full queue");
  stretch_ack_a: assert property (scl_oe_o |-> sda_oe_o)
    else $error("stretch outside an acknowledge");
  head_hold_a: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_req_o))
    else $error("queue head lost");
  index_idle_a: assert property (!busy_o |=> $stable(rd_index_o))
    else $error("index moved while idle");

  cover property ($rose(busy_o));
  cover property ($rose(scl_oe_o));
  cover property (wr_valid_o && wr_ready_i);
endmodule : i2c_target_checker

// *** i2c_bus_master.sv ***
// bus master model driving scl and sda through open-drain releases
// assumes the bench wires the bus as a wired and with pull-ups
`timescale 1ns/1ns

module i2c_bus_master #(
  parameter int T_LO = 1610,
  parameter int T_HI = 650
) (
  output logic scl_drv_o, // low pulls scl down
  output logic sda_drv_o, // low pulls sda down
  input wire logic scl_i, // scl line level
  input wire logic sda_i // sda line level
);
  initial begin
    scl_drv_o = 1'b1;
    sda_drv_o = 1'b1;
  end

  // waiting out a stretch is bounded so a stuck target cannot hang the run
  task automatic bit_cyc(input logic v, output logic s);
    int n;
    #(T_LO / 2);
    sda_drv_o = v;
    #(T_LO / 2);
    scl_drv_o = 1'b1;
    n = 0;
    while (!scl_i && n < 20000) begin
      #40;
      n++;
    end
    s = sda_i;
    #T_HI;
    scl_drv_o = 1'b0;
  endtask : bit_cyc

  task automatic start;
    #(T_LO / 2);
    sda_drv_o = 1'b1;
    #(T_LO / 2);
    scl_drv_o = 1'b1;
    #T_HI;
    sda_drv_o = 1'b0;
    #T_HI;
    scl_drv_o = 1'b0;
  endtask : start

  task automatic stop;
    #(T_LO / 2);
    sda_drv_o = 1'b0;
    #(T_LO / 2);
    scl_drv_o = 1'b1;
    #T_HI;
    sda_drv_o = 1'b1;
    #T_HI;
  endtask : stop

  // tx of all ones releases the line for a read byte
  task automatic xfer(input logic [7:0] tx, input logic ack_v,
                      output logic [7:0] rx, output logic ack_s);
    for (int i = 7; i >= 0; i--) bit_cyc(tx[i], rx[i]);
    bit_cyc(ack_v, ack_s);
  endtask : xfer
endmodule : i2c_bus_master

// *** i2c_register_target_port_bench.sv ***
// self-checking bench for the two-wire register target port
// assumes the master model of i2c_bus_master.sv on a pulled-up bus
`timescale 1ns/1ns

module i2c_register_target_port_bench;
  import i2c_target_pkg::*;
  logic sys_clk_i;
  logic rstn_i;
  logic wr_ready_i;
  logic sda_o, sda_oe_o, scl_o, scl_oe_o, busy_o, wr_valid_o;
  wr_req_s wr_req_o;
  logic [7:0] rd_index_o;
  logic [7:0] rd_data_i;
  logic m_scl, m_sda;
  wire scl_w = m_scl & (scl_oe_o ? scl_o : 1'b1);
  wire sda_w = m_sda & (sda_oe_o ? sda_o : 1'b1);
  int errors = 0;
  int check_count = 0;
  wr_req_s popped[$];

  // register file model: each register reads as its index xor 5a
  assign rd_data_i = rd_index_o ^ 8'h5a;

  i2c_register_target_port DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .scl_o(scl_o), .scl_oe_o(scl_oe_o), .busy_o(busy_o),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_req_o(wr_req_o),
    .rd_index_o(rd_index_o), .rd_data_i(rd_data_i));
  i2c_bus_master m (.scl_drv_o(m_scl), .sda_drv_o(m_sda), .scl_i(scl_w),
    .sda_i(sda_w));

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (wr_valid_o && wr_ready_i) popped.push_back(wr_req_o);
  end

  task automatic check(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic a;
    m.xfer(b, 1'b1, rx, a);
    check("ack", {15'h0, exp_ack}, {15'h0, ~a});
  endtask : send

  task automatic t_write;
    popped.delete();
    m.start();
    repeat (8) @(negedge sys_clk_i);
    check("busy", 16'h1, {15'h0, busy_o});
    send(8'hb2, 1'b1);
    send(8'h04, 1'b1);
    send(8'ha5, 1'b1);
    send(8'h3c, 1'b1);
    m.stop();
    repeat (8) @(negedge sys_clk_i);
    check("idle", 16'h0, {15'h0, busy_o});
    check("words", 16'h2, 16'(popped.size()));
    check("w0", 16'h04a5, popped[0]);
    check("w1", 16'h053c, popped[1]);
    $display("write test done");
  endtask : t_write

  task automatic t_foreign;
    popped.delete();
    m.start();
    send(8'hb4, 1'b0);
    send(8'h04, 1'b0);
    m.stop();
    repeat (8) @(negedge sys_clk_i);
    check("foreign", 16'h0, 16'(popped.size()));
    $display("foreign test done");
  endtask : t_foreign

  task automatic t_read;
    logic [7:0] rx;
    logic a;
    m.start();
    send(8'hb2, 1'b1);
    send(8'h10, 1'b1);
    m.start();
    send(8'hb3, 1'b1);
    m.xfer(8'hff, 1'b0, rx, a);
    check("rd0", 16'h004a, {8'h0, rx});
    m.xfer(8'hff, 1'b1, rx, a);
    check("rd1", 16'h004b, {8'h0, rx});
    check("slot", 16'h1, {15'h0, a});
    m.stop();
    check("index", 16'h0011, {8'h0, rd_index_o});
    $display("read test done");
  endtask : t_read

  task automatic t_full;
    int n;
    popped.delete();
    @(negedge sys_clk_i);
    wr_ready_i = 1'b0;
    m.start();
    send(8'hb2, 1'b1);
    send(8'h20, 1'b1);
    fork
      for (int i = 0; i < 17; i++) send(8'(i), 1'b1);
      begin
        n = 0;
        while (!scl_oe_o && n < 12000) begin
          @(negedge sys_clk_i);
          n++;
        end
        check("stretch", 16'h1, {15'h0, scl_oe_o});
        // stay stalled one more edge so stretch_full_a samples the rise of scl_oe_o with wr_ready_i still low
        @(negedge sys_clk_i);
        wr_ready_i = 1'b1;
      end
    join
    m.stop();
    repeat (8) @(negedge sys_clk_i);
    check("drained", 16'h0011, 16'(popped.size()));
    for (int i = 0; i < 17; i++) check("word", {8'(32 + i), 8'(i)}, popped[i]);
    check("empty", 16'h0, {15'h0, wr_valid_o});
    $display("full test done");
  endtask : t_full

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  initial begin
    #2000000;
    errors++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    rstn_i = 1'b0;
    wr_ready_i = 1'b1;
    repeat (6) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    t_write();
    t_foreign();
    t_read();
    t_full();
    end_sim();
  end
endmodule : i2c_register_target_port_bench

bind i2c_register_target_port i2c_target_checker chk (.sys_clk_i(sys_clk_i),
  .rstn_i(rstn_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .busy_o(busy_o),
  .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_req_o(wr_req_o),
  .rd_index_o(rd_index_o));
